// [shared/wdt_pkg.sv]
// Constants and types for the watchdog and interval timer block
// Overview of operation
// RULE_01: Eight-bit readable, writable up-counter on count ticks
// RULE_02: Run bit clear halts and zeroes counter
// RULE_03: Control bit 6 picks interval or watchdog
// RULE_04: Control bits 2..0 pick count clock rate
// RULE_05: Watchdog wrap FF to 00 sets overflow flag
// RULE_06: Flag clears by zero write after reading one
// RULE_07: Writing one to flag does nothing
// RULE_08: Reset enable bit makes overflow reset chip
// RULE_09: Interval wrap raises interrupt, keeps counting
// RULE_10: Software rewrites counter before it wraps
package wdt_pkg;

    // Printed offsets are register indices; byte address is four times
    localparam logic [31:0] idx_timer_control_status = 32'h00ff_ffa4;
    localparam logic [31:0] idx_timer_count_value    = 32'h00ff_ffa5;
    localparam logic [31:0] idx_reset_control_status = 32'h00ff_ffa7;
    localparam logic [31:0] idx_irq_status           = 32'h00ff_ffa8;
    localparam logic [31:0] idx_irq_mask             = 32'h00ff_ffa9;

    localparam logic [31:0] addr_timer_control_status = idx_timer_control_status << 2;
    localparam logic [31:0] addr_timer_count_value    = idx_timer_count_value << 2;
    localparam logic [31:0] addr_reset_control_status = idx_reset_control_status << 2;
    localparam logic [31:0] addr_irq_status           = idx_irq_status << 2;
    localparam logic [31:0] addr_irq_mask             = idx_irq_mask << 2;

    // Field positions
    localparam int pos_timer_mode_sel        = 6;
    localparam int pos_count_run             = 5;
    localparam int pos_count_clock_sel       = 0;
    localparam int pos_overflow_flag         = 7;
    localparam int pos_overflow_reset_enable = 6;
    localparam int pos_irq_watchdog          = 0;
    localparam int pos_irq_interval          = 1;

    localparam logic [7:0] count_reset_value = 8'h00;
    localparam logic [7:0] count_all_ones    = 8'hff;
    localparam logic [1:0] irq_reset_value   = 2'h0;
    localparam logic [1:0] htrans_nonseq     = 2'h2;
    localparam logic [1:0] hresp_okay        = 2'h0;

    // Prescaler width and tap per count clock select value
    localparam int presc_width = 14;
    localparam logic [3:0] clk_tap [8] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'hd};

    typedef struct packed {
        logic       timer_mode_sel;
        logic       count_run;
        logic [2:0] count_clock_sel;
    } timer_ctrl_t;

    typedef struct packed {
        logic overflow_flag;
        logic overflow_reset_enable;
    } reset_ctrl_t;

    localparam timer_ctrl_t timer_ctrl_reset = '{1'b0, 1'b0, 3'h0};
    localparam reset_ctrl_t reset_ctrl_reset = '{1'b0, 1'b0};

    typedef enum logic {bus_idle, bus_data} bus_state_t;

endpackage

// [logic/watchdog_interval_timer.sv]
// Watchdog and interval timer with an AHB-Lite register slave
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
module watchdog_interval_timer
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic             chip_reset_req
);

    wdt_pkg::timer_ctrl_t ctrl_ff;
    wdt_pkg::reset_ctrl_t rctrl_ff;
    wdt_pkg::bus_state_t  bus_state_ff;

    logic [7:0]                     watchdog_count_ff;
    logic [wdt_pkg::presc_width-1:0] presc_ff;
    logic                           tick_ff;
    logic                           flag_armed_ff;
    logic [1:0]                     irq_status_ff;
    logic [1:0]                     irq_mask_ff;
    logic [31:0]                    addr_ff;
    logic                           write_ff;
    logic [31:0]                    hrdata_ff;
    logic                           hreadyout_ff;
    logic                           irq_ff;
    logic                           chip_reset_ff;

    logic        accept;
    logic        commit;
    logic        wr_ctrl;
    logic        wr_count;
    logic        wr_rctrl;
    logic        wr_istat;
    logic        wr_imask;
    logic        rd_rctrl;
    logic        wrap;
    logic        wd_ovf;
    logic        iv_ovf;
    logic [31:0] rd_value;
    logic [wdt_pkg::presc_width-1:0] tick_mask;
    logic [7:0]  nxt_count;

    // Address phase taken only for a selected nonsequential transfer
    assign accept = hsel && hready && (htrans == wdt_pkg::htrans_nonseq);
    // One wait cycle: writes land before the next read is sampled
    assign commit = (bus_state_ff == wdt_pkg::bus_data);

    assign wr_ctrl  = commit && write_ff && (addr_ff == wdt_pkg::addr_timer_control_status);
    assign wr_count = commit && write_ff && (addr_ff == wdt_pkg::addr_timer_count_value);
    assign wr_rctrl = commit && write_ff && (addr_ff == wdt_pkg::addr_reset_control_status);
    assign wr_istat = commit && write_ff && (addr_ff == wdt_pkg::addr_irq_status);
    assign wr_imask = commit && write_ff && (addr_ff == wdt_pkg::addr_irq_mask);
    assign rd_rctrl = commit && !write_ff && (addr_ff == wdt_pkg::addr_reset_control_status);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_state_ff <= wdt_pkg::bus_idle;
            addr_ff      <= 32'h0000_0000;
            write_ff     <= 1'b0;
            hreadyout_ff <= 1'b1;
        end
        else
        begin
            case (bus_state_ff)
                wdt_pkg::bus_idle:
                begin
                    if (accept)
                    begin
                        bus_state_ff <= wdt_pkg::bus_data;
                        addr_ff      <= haddr;
                        write_ff     <= hwrite;
                        hreadyout_ff <= 1'b0;
                    end
                end
                wdt_pkg::bus_data:
                begin
                    bus_state_ff <= wdt_pkg::bus_idle;
                    hreadyout_ff <= 1'b1;
                end
                default:
                begin
                    bus_state_ff <= wdt_pkg::bus_idle;
                    hreadyout_ff <= 1'b1;
                end
            endcase
        end
    end

    // Unmapped addresses read as zero
    always_comb
    begin
        rd_value = 32'h0000_0000;
        case (addr_ff)
            wdt_pkg::addr_timer_control_status:
            begin
                rd_value[wdt_pkg::pos_timer_mode_sel] = ctrl_ff.timer_mode_sel;
                rd_value[wdt_pkg::pos_count_run]      = ctrl_ff.count_run;
                rd_value[wdt_pkg::pos_count_clock_sel +: 3] = ctrl_ff.count_clock_sel;
            end
            wdt_pkg::addr_timer_count_value:
            begin
                rd_value[7:0] = watchdog_count_ff; // RULE_01
            end
            wdt_pkg::addr_reset_control_status:
            begin
                rd_value[wdt_pkg::pos_overflow_flag]         = rctrl_ff.overflow_flag;
                rd_value[wdt_pkg::pos_overflow_reset_enable] = rctrl_ff.overflow_reset_enable;
            end
            wdt_pkg::addr_irq_status:
            begin
                rd_value[1:0] = irq_status_ff;
            end
            wdt_pkg::addr_irq_mask:
            begin
                rd_value[1:0] = irq_mask_ff;
            end
            default:
            begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hrdata_ff <= 32'h0000_0000;
        end
        else if (commit && !write_ff)
        begin
            hrdata_ff <= rd_value;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_ff <= wdt_pkg::timer_ctrl_reset;
        end
        else if (wr_ctrl)
        begin
            ctrl_ff.timer_mode_sel  <= hwdata[wdt_pkg::pos_timer_mode_sel]; // RULE_03
            ctrl_ff.count_run       <= hwdata[wdt_pkg::pos_count_run];
            ctrl_ff.count_clock_sel <= hwdata[wdt_pkg::pos_count_clock_sel +: 3]; // RULE_04
        end
    end

    // Free-running prescaler; the select picks a tap
    assign tick_mask = wdt_pkg::presc_width'((1 << wdt_pkg::clk_tap[ctrl_ff.count_clock_sel]) - 1); // RULE_04

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            presc_ff <= '0;
            tick_ff  <= 1'b0;
        end
        else
        begin
            presc_ff <= presc_ff + 1'b1;
            tick_ff  <= ((presc_ff & tick_mask) == tick_mask);
        end
    end

    // A counter write wins over the tick, so a kick never loses to a wrap
    assign wrap   = ctrl_ff.count_run && tick_ff && !wr_count
                    && (watchdog_count_ff == wdt_pkg::count_all_ones);
    assign wd_ovf = wrap && ctrl_ff.timer_mode_sel; // RULE_05
    assign iv_ovf = wrap && !ctrl_ff.timer_mode_sel; // RULE_09

    always_comb
    begin
        nxt_count = watchdog_count_ff;
        if (!ctrl_ff.count_run)
        begin
            nxt_count = wdt_pkg::count_reset_value; // RULE_02
        end
        else if (wr_count)
        begin
            nxt_count = hwdata[7:0]; // RULE_01 RULE_10
        end
        else if (tick_ff)
        begin
            nxt_count = watchdog_count_ff + 8'h01; // RULE_01 RULE_02
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            watchdog_count_ff <= wdt_pkg::count_reset_value;
        end
        else
        begin
            watchdog_count_ff <= nxt_count;
        end
    end

    // Clear is armed only by a read that saw the flag set
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            flag_armed_ff <= 1'b0;
        end
        else if (rd_rctrl)
        begin
            flag_armed_ff <= rctrl_ff.overflow_flag; // RULE_06
        end
        else if (wr_rctrl)
        begin
            flag_armed_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rctrl_ff <= wdt_pkg::reset_ctrl_reset;
        end
        else
        begin
            if (wr_rctrl)
            begin
                rctrl_ff.overflow_reset_enable <= hwdata[wdt_pkg::pos_overflow_reset_enable];
            end
            if (wd_ovf)
            begin
                rctrl_ff.overflow_flag <= 1'b1; // RULE_05
            end
            else if (wr_rctrl && flag_armed_ff && !hwdata[wdt_pkg::pos_overflow_flag])
            begin
                rctrl_ff.overflow_flag <= 1'b0; // RULE_06 RULE_07
            end
        end
    end

    // One-cycle reset request to the chip reset controller
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            chip_reset_ff <= 1'b0;
        end
        else
        begin
            chip_reset_ff <= wd_ovf && rctrl_ff.overflow_reset_enable; // RULE_08
        end
    end

    // Sticky event bits; a new event beats a same-cycle clear
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_status_ff <= wdt_pkg::irq_reset_value;
        end
        else
        begin
            irq_status_ff <= (irq_status_ff & ~({2{wr_istat}} & hwdata[1:0]))
                             | {iv_ovf, wd_ovf}; // RULE_09
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_mask_ff <= wdt_pkg::irq_reset_value;
        end
        else if (wr_imask)
        begin
            irq_mask_ff <= hwdata[1:0];
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign hrdata         = hrdata_ff;
    assign hreadyout      = hreadyout_ff;
    assign hresp          = wdt_pkg::hresp_okay[0];
    assign irq            = irq_ff;
    assign chip_reset_req = chip_reset_ff;

endmodule // watchdog_interval_timer

// [testbench/watchdog_interval_timer_assertions.sv]
// Bus and reset request checks for the watchdog timer
`timescale 1ns/10ps
module wdt_checker
(
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        chip_reset_req
);
    wire logic mapped = haddr inside {wdt_pkg::addr_timer_control_status, wdt_pkg::addr_timer_count_value,
        wdt_pkg::addr_reset_control_status, wdt_pkg::addr_irq_status, wdt_pkg::addr_irq_mask};
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    sequence taken;
        hsel && hready && htrans == wdt_pkg::htrans_nonseq;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence rd_unmapped;
        taken ##0 (!hwrite && !mapped);
    endsequence
    chk_wait_state: assert property (taken |=> one_wait)
        else $error("transfer not answered after one wait");
    chk_ready_low: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    chk_ready_cause: assert property ($fell(hreadyout) |-> $past(hsel && hready && htrans == 2'h2))
        else $error("wait without transfer");
    chk_unmapped_read: assert property (rd_unmapped |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_read_hold: assert property ($changed(hrdata) |-> $past(!hreadyout))
        else $error("read data moved outside data phase");
    chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_reset_pulse: assert property (chip_reset_req |=> !chip_reset_req)
        else $error("reset request longer than one cycle");
endmodule // wdt_checker

bind watchdog_interval_timer wdt_checker u_checker (.*);

// [testbench/watchdog_interval_timer_test.sv]
// Self-checking bench for the watchdog and interval timer
`timescale 1ns/10ps
module watchdog_interval_timer_test;
    logic        clock;
    logic        resetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        chip_reset_req;
    logic [31:0] d;
    logic [31:0] v;
    int          p;
    int          pulses;
    int          err_total;
    int          comparisons;
    localparam logic [31:0] a_ctl = wdt_pkg::addr_timer_control_status;
    localparam logic [31:0] a_cnt = wdt_pkg::addr_timer_count_value;
    localparam logic [31:0] a_rst = wdt_pkg::addr_reset_control_status;
    localparam logic [31:0] a_sts = wdt_pkg::addr_irq_status;
    localparam logic [31:0] a_msk = wdt_pkg::addr_irq_mask;
    localparam logic [31:0] regs [6] = '{a_ctl, a_cnt, a_rst, a_sts, a_msk, 32'h0000_0010};

    watchdog_interval_timer u_dut
    (
        .clock          (clock),
        .resetn         (resetn),
        .hsel           (hsel),
        .haddr          (haddr),
        .htrans         (htrans),
        .hwrite         (hwrite),
        .hsize          (3'h2),
        .hwdata         (hwdata),
        .hready         (hreadyout),
        .hrdata         (hrdata),
        .hreadyout      (hreadyout),
        .hresp          (hresp),
        .irq            (irq),
        .chip_reset_req (chip_reset_req)
    );

    always @(posedge clock) pulses <= pulses + int'(chip_reset_req === 1'b1);

    task automatic print_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_rng(input string n, input int lo, input int hi, input logic [31:0] g);
        comparisons++;
        if ($isunknown(g) || g < lo || g > hi)
        begin
            err_total++;
            $display("mismatch %s expected %0d..%0d seen %h", n, lo, hi, g);
        end
    endtask

    // Control register keeps only mode, run and clock select
    function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
        return w & ((32'h1 << wdt_pkg::pos_timer_mode_sel) | (32'h1 << wdt_pkg::pos_count_run)
                    | (32'h7 << wdt_pkg::pos_count_clock_sel));
    endfunction

    // Whole count ticks in a span of clocks at one prescaler tap
    function automatic int ticks_in(input int span, input int tap);
        return span >> tap;
    endfunction

    // Caller stands just after a rising edge; ends just after one
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= wdt_pkg::htrans_nonseq;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        xfer(1'b1, a, wd);
    endtask

    task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        cmp(n, e, d);
    endtask

    task automatic rr(input string n, input logic [31:0] a, input int lo, input int hi);
        xfer(1'b0, a, 32'h0);
        cmp_rng(n, lo, hi, d);
    endtask

    task automatic wrap_run(input logic [31:0] ctl);
        p = pulses;
        wr(a_ctl, ctl);
        wr(a_cnt, 32'hf0);
        repeat (60) @(posedge clock);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial
    begin
        #240000;
        err_total++;
        print_verdict();
    end

    initial
    begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pulses = 0;
        void'($urandom(32'h7306a227));
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        wr(32'h0000_0010, $urandom);
        foreach (regs[i]) rc("reset value", regs[i], 32'h0);
        repeat (8)
        begin
            v = $urandom & 32'hffff_ffdf;
            wr(a_ctl, v);
            rc("control", a_ctl, exp_ctrl(v));
            wr(a_cnt, v);
            rc("count halted", a_cnt, 32'h0);
        end
        // Slowest rate lets at most one tick land between write and read
        wr(a_ctl, 32'h27);
        repeat (8)
        begin
            v = $urandom_range(254);
            wr(a_cnt, v);
            rr("count written", a_cnt, v, v + 1);
        end
        // Every select value, waiting four ticks of its own rate
        for (int s = 0; s < 8; s++)
        begin
            int w;
            int t;
            t = wdt_pkg::clk_tap[s];
            w = 4 << t;
            wr(a_ctl, 32'h0);
            wr(a_ctl, 32'h20 | s);
            repeat (w) @(posedge clock);
            rr("count rate", a_cnt, ticks_in(w, t), ticks_in(w + 2, t) + 1);
        end
        wr(a_msk, 32'h3);
        wrap_run(32'h60);
        cmp("reset pulses", p, pulses);
        cmp("irq", 32'h1, {31'h0, irq});
        rc("flag set", a_rst, 32'h80);
        wr(a_rst, 32'h80);
        wr(a_rst, 32'h00);
        rc("flag kept", a_rst, 32'h80);
        wr(a_rst, 32'h80);
        rc("flag one write", a_rst, 32'h80);
        wr(a_rst, 32'h00);
        rc("flag cleared", a_rst, 32'h0);
        // Unkicked, the count would wrap well inside this span
        repeat (6)
        begin
            wr(a_cnt, 32'h80);
            repeat (100) @(posedge clock);
        end
        rc("kicked no flag", a_rst, 32'h0);
        wr(a_ctl, 32'h0);
        wr(a_rst, 32'h40);
        wrap_run(32'h60);
        cmp("reset pulses", p + 1, pulses);
        rc("flag and enable", a_rst, 32'hc0);
        wr(a_rst, 32'h0);
        wr(a_ctl, 32'h0);
        wr(a_sts, 32'h3);
        wr(a_msk, 32'h0);
        wrap_run(32'h20);
        cmp("irq masked", 32'h0, {31'h0, irq});
        cmp("reset pulses", p, pulses);
        rc("interval status", a_sts, 32'h2);
        rc("no flag", a_rst, 32'h0);
        rr("still counting", a_cnt, 8, 48);
        wr(a_msk, 32'h2);
        repeat (2) @(posedge clock);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(a_sts, 32'h2);
        repeat (2) @(posedge clock);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        print_verdict();
    end
endmodule // watchdog_interval_timer_test
